//--- rtl/pio_pkg.sv
// How it works
// - ten port D pins, one latch each
// - open-drain: latch zero pulls low, else floats
// - P0/P1/P3 read pins while latch is one
// - P0/P1 pins have pull-up and wakeup
// - P4 pull-up and wakeup switchable by software
// - P2 two inputs, bit one is irq
// - irq pin requests interrupt and wakes backup
// - timer pin toggles on timer 2 underflow
// - control bit picks latch or toggle on D9
// - reset pin low on watchdog or low voltage
// - voltage detector runs while enable pin high
// - outputs float after reset until written zero, except D9 with toggle selected
// - return level bit sets irq wakeup polarity
// - grounded enabled P4 pins keep backup from holding
// - P4 per-pin pull-up and wakeup control bits
// - skip instruction tests irq pin level
// - carrier pin is push-pull, always driven
// - pointer register selects port D bit
package pio_pkg;
  localparam int BITOUT_W = 10;
  localparam int NIB_W = 4;
  localparam int PTR_W = 4;
  localparam logic [9:0] BITOUT_RST = 10'h3FF;
  localparam logic [3:0] NIB_RST = 4'hF;
  localparam logic [3:0] P4CTL_RST = 4'h0;
  localparam logic TOG_RST = 1'b0;
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam int TOGGLE_PIN = 9;
  localparam logic [3:0] PORT_P0 = 4'h0;
  localparam logic [3:0] PORT_P1 = 4'h1;
  localparam logic [3:0] PORT_P2 = 4'h2;
  localparam logic [3:0] PORT_P3 = 4'h3;
  localparam logic [3:0] PORT_P4 = 4'h4;
endpackage

//--- rtl/pio_port_io.sv
`timescale 1ns/100ps
module pio_port_io import pio_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set_bitout_instr,
  input wire logic reset_bitout_instr,
  input wire logic clear_all_bitout_instr,
  input wire logic [PTR_W-1:0] digitPtr,
  input wire logic write_port0_instr,
  input wire logic write_port1_instr,
  input wire logic write_port3_instr,
  input wire logic read_port0_instr,
  input wire logic read_port1_instr,
  input wire logic read_port2_instr,
  input wire logic read_port3_instr,
  input wire logic read_port4_instr,
  input wire logic [NIB_W-1:0] accIn,
  output logic [NIB_W-1:0] accOut,
  output logic accValid,
  input wire logic skip_on_irq_pin_level,
  output logic skipTaken,
  input wire logic pullupWrite,
  input wire logic [NIB_W-1:0] pullup_ctrl,
  input wire logic wakeupWrite,
  input wire logic [NIB_W-1:0] wakeup_ctrl,
  input wire logic timer_pin_select,
  input wire logic irq_return_level,
  input wire logic timer2Underflow,
  input wire logic carrierWave,
  input wire logic watchdogReset,
  input wire logic lowVoltage,
  input wire logic vdrop_detect_enable,
  input wire logic [BITOUT_W-1:0] bitoutIn,
  output logic [BITOUT_W-1:0] bitoutOe,
  input wire logic [NIB_W-1:0] port0In,
  output logic [NIB_W-1:0] port0Oe,
  output logic [NIB_W-1:0] port0PullupEn,
  input wire logic [NIB_W-1:0] port1In,
  output logic [NIB_W-1:0] port1Oe,
  output logic [NIB_W-1:0] port1PullupEn,
  input wire logic [1:0] port2In,
  input wire logic [NIB_W-1:0] port3In,
  output logic [NIB_W-1:0] port3Oe,
  input wire logic [NIB_W-1:0] port4In,
  output logic [NIB_W-1:0] port4PullupEn,
  output logic carrier_out,
  output logic resetPinOe,
  output logic vdropRun,
  output logic extIrqReq,
  output logic wakeupReq
);
  //////////////////////////////////////////////////////////////////
  // helpers
  // pointer values past the last pin are ignored, not wrapped
  function automatic logic ptrInRange(
    input logic [PTR_W-1:0] ptr
  );
    ptrInRange = ptr < PTR_W'(BITOUT_W);
  endfunction

  // a one releases the pin, a zero pulls it low
  function automatic logic [NIB_W-1:0] drainEnable(
    input logic [NIB_W-1:0] latch
  );
    drainEnable = ~latch;
  endfunction

  // a driven-low pin would only read back its own zero, so mask it
  function automatic logic [NIB_W-1:0] quasiRead(
    input logic [NIB_W-1:0] pins,
    input logic [NIB_W-1:0] latch
  );
    quasiRead = pins & latch;
  endfunction

  // any enabled pin pulled low by a key
  function automatic logic anyLow(
    input logic [NIB_W-1:0] pins,
    input logic [NIB_W-1:0] enable
  );
    anyLow = |(enable & ~pins);
  endfunction

  //////////////////////////////////////////////////////////////////
  // port D latches; a one means released, so reset leaves pins floating
  logic [BITOUT_W-1:0] bitout_q;
  logic [BITOUT_W-1:0] bitout_d;

  always_comb begin
    bitout_d = bitout_q;
    if (clear_all_bitout_instr) begin
      bitout_d = BITOUT_RST;
    end else if (set_bitout_instr && ptrInRange(digitPtr)) begin
      bitout_d[digitPtr] = 1'b1;
    end else if (reset_bitout_instr && ptrInRange(digitPtr)) begin
      bitout_d[digitPtr] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitout_q <= BITOUT_RST;
    end else begin
      bitout_q <= bitout_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // port P0 latch
  logic [NIB_W-1:0] p0_q;
  logic [NIB_W-1:0] p0_d;

  always_comb begin
    p0_d = p0_q;
    if (write_port0_instr) begin
      p0_d = accIn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_q <= NIB_RST;
    end else begin
      p0_q <= p0_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // port P1 latch
  logic [NIB_W-1:0] p1_q;
  logic [NIB_W-1:0] p1_d;

  always_comb begin
    p1_d = p1_q;
    if (write_port1_instr) begin
      p1_d = accIn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p1_q <= NIB_RST;
    end else begin
      p1_q <= p1_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // port P3 latch
  logic [NIB_W-1:0] p3_q;
  logic [NIB_W-1:0] p3_d;

  always_comb begin
    p3_d = p3_q;
    if (write_port3_instr) begin
      p3_d = accIn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p3_q <= NIB_RST;
    end else begin
      p3_q <= p3_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // port P4 pull-up and wakeup controls
  // whole nibble at once: there is no per-pin write path
  logic [NIB_W-1:0] pu_q;
  logic [NIB_W-1:0] pu_d;
  logic [NIB_W-1:0] kw_q;
  logic [NIB_W-1:0] kw_d;

  always_comb begin
    pu_d = pu_q;
    kw_d = kw_q;
    if (pullupWrite) begin
      pu_d = pullup_ctrl;
    end
    if (wakeupWrite) begin
      kw_d = wakeup_ctrl;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_q <= P4CTL_RST;
      kw_q <= P4CTL_RST;
    end else begin
      pu_q <= pu_d;
      kw_q <= kw_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // timer toggle: divides the underflow pulse by two
  logic tog_q;
  logic tog_d;

  always_comb begin
    tog_d = tog_q;
    if (timer2Underflow) begin
      tog_d = ~tog_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_q <= TOG_RST;
    end else begin
      tog_q <= tog_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // pin drivers: enable high means pulling the pin low
  always_comb begin
    bitoutOe = ~bitout_q;
    // D9 follows the toggle when selected; toggle one floats the pin
    if (timer_pin_select) begin
      bitoutOe[TOGGLE_PIN] = ~tog_q;
    end
    port0Oe = drainEnable(p0_q);
    port1Oe = drainEnable(p1_q);
    port3Oe = drainEnable(p3_q);
    port0PullupEn = NIB_RST;
    port1PullupEn = NIB_RST;
    port4PullupEn = pu_q;
    carrier_out = carrierWave;
    resetPinOe = watchdogReset | lowVoltage;
    vdropRun = vdrop_detect_enable;
    extIrqReq = port2In[1];
  end

  //////////////////////////////////////////////////////////////////
  // wakeup sources; combinational so they work with the clock stopped
  logic irqWake;
  logic portWake;
  logic p4Wake;

  always_comb begin
    // a pin sitting at the return level wakes at once
    irqWake = port2In[1] == irq_return_level;
    portWake = anyLow(port0In, NIB_RST) | anyLow(port1In, NIB_RST);
    // an enabled P4 pin tied low keeps asking, so back-up never holds
    p4Wake = anyLow(port4In, kw_q);
    wakeupReq = irqWake | portWake | p4Wake;
  end

  //////////////////////////////////////////////////////////////////
  // instruction reads: registered data, one-cycle valid
  logic [NIB_W-1:0] acc_q;
  logic [NIB_W-1:0] acc_d;
  logic accV_q;
  logic accV_d;

  always_comb begin
    acc_d = acc_q;
    accV_d = 1'b0;
    // fixed priority keeps two reads in one cycle well defined
    if (read_port0_instr) begin
      acc_d = quasiRead(port0In, p0_q);
      accV_d = 1'b1;
    end else if (read_port1_instr) begin
      acc_d = quasiRead(port1In, p1_q);
      accV_d = 1'b1;
    end else if (read_port2_instr) begin
      acc_d = {2'h0, port2In};
      accV_d = 1'b1;
    end else if (read_port3_instr) begin
      acc_d = quasiRead(port3In, p3_q);
      accV_d = 1'b1;
    end else if (read_port4_instr) begin
      acc_d = port4In;
      accV_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= ACC_RST;
      accV_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      accV_q <= accV_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // skip test looks at the pin in the cycle of the instruction
  logic skip_q;
  logic skip_d;

  always_comb begin
    skip_d = skip_on_irq_pin_level & port2In[1];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= skip_d;
    end
  end

  assign accOut = acc_q;
  assign accValid = accV_q;
  assign skipTaken = skip_q;
endmodule

//--- test/pio_properties.sv
`timescale 1ns/100ps
module pio_checker(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic write_port0_instr,
  input wire logic [3:0] accIn,
  input wire logic [3:0] port0Oe,
  input wire logic clear_all_bitout_instr,
  input wire logic [9:0] bitoutOe,
  input wire logic skip_on_irq_pin_level,
  input wire logic skipTaken,
  input wire logic [1:0] port2In,
  input wire logic extIrqReq,
  input wire logic watchdogReset,
  input wire logic lowVoltage,
  input wire logic resetPinOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_p0_write: assert property (
    write_port0_instr |=> port0Oe == ~$past(accIn)) else $error("p0 write");
  a_p0_hold: assert property (
    !write_port0_instr |=> $stable(port0Oe)) else $error("p0 hold");
  a_clear_all: assert property (
    clear_all_bitout_instr |=> bitoutOe[8:0] == 9'h000) else $error("clear all");
  a_start_float: assert property (
    $rose(rst_n) |-> port0Oe == 4'h0 && bitoutOe[8:0] == 9'h000) else $error("float");
  a_skip_level: assert property (
    skip_on_irq_pin_level |=> skipTaken == $past(port2In[1])) else $error("skip");
  a_irq_pin: assert property (
    extIrqReq == port2In[1]) else $error("irq");
  a_wdog_pull: assert property (
    watchdogReset |-> resetPinOe) else $error("rst pull");
  a_rst_idle: assert property (
    !(watchdogReset || lowVoltage) |-> !resetPinOe) else $error("rst idle");
endmodule
bind pio_port_io pio_checker u_chk(.*);

//--- test/pio_pins.sv
`timescale 1ns/100ps
module pio_pins(
  input wire logic [3:0] port0Oe,
  input wire logic [3:0] port1Oe,
  input wire logic [3:0] port4PullupEn,
  input wire logic [3:0] keyLow0,
  input wire logic [3:0] keyLow4,
  output logic [3:0] port0In,
  output logic [3:0] port1In,
  output logic [3:0] port4In
);
  assign port0In = ~(port0Oe | keyLow0);
  assign port1In = ~port1Oe;
  // no pull-up: idle pin reads low, the harsher case
  assign port4In = port4PullupEn & ~keyLow4;
endmodule

//--- test/port_io_pin_logic_test.sv
`timescale 1ns/100ps
module port_io_pin_logic_test import pio_pkg::*;;
`define CK(a,b) begin checks++; if ((a)!==(b)) begin nErrors++; $display("Error %0t %h %h",$time,a,b); end end
`define P(s) begin s=1; @(negedge clk); s=0; end
  int nErrors=0, checks=0;
  logic clk=0, rst_n=0, set_bitout_instr=0, reset_bitout_instr=0, clear_all_bitout_instr=0;
  logic write_port0_instr=0, write_port1_instr=0, write_port3_instr=0, read_port0_instr=0;
  logic read_port1_instr=0, read_port2_instr=0, read_port3_instr=0, read_port4_instr=0;
  logic skip_on_irq_pin_level=0, pullupWrite=0, wakeupWrite=0, timer_pin_select=0;
  logic irq_return_level=1, timer2Underflow=0, carrierWave=0, watchdogReset=0, lowVoltage=0;
  logic vdrop_detect_enable=0, accValid, skipTaken, carrier_out, resetPinOe, vdropRun;
  logic extIrqReq, wakeupReq;
  logic [3:0] digitPtr=0, accIn=0, pullup_ctrl=0, wakeup_ctrl=0, port3In=4'hF;
  logic [3:0] keyLow0=0, keyLow4=0, accOut, port0In, port0Oe, port0PullupEn, port1In;
  logic [3:0] port1Oe, port1PullupEn, port3Oe, port4In, port4PullupEn;
  logic [1:0] port2In=0;
  logic [9:0] bitoutIn=0, bitoutOe;
  always #4 clk = ~clk;
  pio_port_io u_dut(.*);
  pio_pins u_pins(.*);
  task summarize;
    $display("checks %0d errors %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #20000;
    nErrors++;
    summarize;
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    `CK({port0Oe, bitoutOe}, 14'h0000)
    `CK({port0PullupEn, port1PullupEn}, 8'hFF)
    accIn = 4'h5;
    `P(write_port0_instr)
    `CK(port0Oe, 4'hA)
    keyLow0 = 4'h1;
    `P(read_port0_instr)
    `CK({accValid, accOut}, 5'h14)
    accIn = 4'h6;
    `P(write_port1_instr)
    `P(read_port1_instr)
    `CK({port1Oe, accValid, accOut}, 9'h136)
    accIn = 4'h3;
    `P(write_port3_instr)
    `P(read_port3_instr)
    `CK({port3Oe, accValid, accOut}, 9'h193)
    port2In = 2'h1;
    `P(read_port2_instr)
    `CK({accValid, accOut}, 5'h11)
    $display("port test done");
    digitPtr = 4'h3;
    `P(reset_bitout_instr)
    `CK(bitoutOe, 10'h008)
    @(negedge clk);
    digitPtr = 4'hA;
    `P(reset_bitout_instr)
    `CK(bitoutOe, 10'h008)
    digitPtr = 4'h3;
    `P(set_bitout_instr)
    `CK(bitoutOe, 10'h000)
    digitPtr = 4'h5;
    `P(reset_bitout_instr)
    `CK(bitoutOe, 10'h020)
    `P(clear_all_bitout_instr)
    `CK(bitoutOe, 10'h000)
    timer_pin_select = 1;
    @(negedge clk);
    `CK(bitoutOe, 10'h200)
    `P(timer2Underflow)
    `CK(bitoutOe, 10'h000)
    $display("bit test done");
    {accIn, keyLow0, pullup_ctrl, wakeup_ctrl} = 16'hF0FF;
    `P(write_port0_instr)
    `P(write_port1_instr)
    `P(pullupWrite)
    `P(wakeupWrite)
    `CK({port4PullupEn, wakeupReq}, 5'h1E)
    keyLow4 = 4'h4;
    @(negedge clk);
    `CK(wakeupReq, 1'h1)
    `P(read_port4_instr)
    `CK({accValid, accOut}, 5'h1B)
    {keyLow4, port2In} = 6'h02;
    `P(skip_on_irq_pin_level)
    `CK({extIrqReq, skipTaken, wakeupReq}, 3'h7)
    irq_return_level = 0;
    @(negedge clk);
    `CK(wakeupReq, 1'h0)
    {watchdogReset, vdrop_detect_enable, carrierWave} = 3'h7;
    @(negedge clk);
    `CK({resetPinOe, vdropRun, carrier_out}, 3'h7)
    {watchdogReset, lowVoltage, vdrop_detect_enable, carrierWave} = 4'h4;
    @(negedge clk);
    `CK({resetPinOe, vdropRun, carrier_out}, 3'h4)
    $display("pin test done");
    summarize;
  end
endmodule
